// *** hdl/lpmr_pkg.sv ***
// Shared constants and types for the mode register bank link
package lpmr_pkg;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned CKE_LOW_WAIT_NS = 100;
  localparam int unsigned CLOCK_STABLE_WAIT_TCK = 5;
  localparam int unsigned POST_CKE_IDLE_WAIT_US = 200;
  localparam int unsigned POST_RESET_IDLE_WAIT_US = 1;
  localparam int unsigned AUTO_INIT_MAX_TIME_US = 10;
  localparam int unsigned ZQ_INIT_WAIT_US = 1;
  localparam int unsigned CKE_LOW_WAIT_CYC = (CKE_LOW_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CLOCK_STABLE_WAIT_CYC = CLOCK_STABLE_WAIT_TCK;
  localparam int unsigned POST_CKE_IDLE_WAIT_CYC = (POST_CKE_IDLE_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned POST_RESET_IDLE_WAIT_CYC = (POST_RESET_IDLE_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned AUTO_INIT_MAX_TIME_CYC = (AUTO_INIT_MAX_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned ZQ_INIT_WAIT_CYC = (ZQ_INIT_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Register addresses
  localparam logic [7:0] ADDR_DEVICE_INFORMATION = 8'h00;
  localparam logic [7:0] ADDR_DEVICE_FEATURE_ONE = 8'h01;
  localparam logic [7:0] ADDR_DEVICE_FEATURE_TWO = 8'h02;
  localparam logic [7:0] ADDR_IO_CONFIGURATION = 8'h03;
  localparam logic [7:0] ADDR_REFRESH_RATE_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MAKER_IDENTIFICATION = 8'h05;
  localparam logic [7:0] ADDR_REVISION_FIRST = 8'h06;
  localparam logic [7:0] ADDR_REVISION_SECOND = 8'h07;
  localparam logic [7:0] ADDR_WIDTH_DENSITY_TYPE = 8'h08;
  localparam logic [7:0] ADDR_TEST_MODE_CONTROL = 8'h09;
  localparam logic [7:0] ADDR_IO_CALIBRATION_COMMAND = 8'h0A;
  localparam logic [7:0] ADDR_PARTIAL_REFRESH_BANK_MASK = 8'h10;
  localparam logic [7:0] ADDR_RESERVED_WRITABLE = 8'h11;
  localparam logic [7:0] ADDR_CALIBRATION_PATTERN_A = 8'h20;
  localparam logic [7:0] ADDR_CALIBRATION_PATTERN_B = 8'h28;
  localparam logic [7:0] ADDR_SOFTWARE_RESET = 8'h3F;
  // Field positions and reset values
  localparam int unsigned AUTO_INIT_STATUS_BIT = 0;
  localparam logic [7:0] DEVICE_INFO_USED_MASK = 8'h1F;
  localparam logic [7:0] REFRESH_RATE_USED_MASK = 8'h87;
  localparam logic [7:0] REFRESH_RATE_RESET = 8'h03;
  localparam logic [7:0] FEATURE_ONE_RESET = 8'h22;
  localparam logic [7:0] ZQ_INIT_CAL_CODE = 8'hFF;
  localparam logic [7:0] UNDEFINED_READ_DATA = 8'h00;
  localparam int unsigned READ_LATENCY = 3;
  // Commands on the command bus
  typedef enum logic [1:0] {
    LPMR_CMD_NOP = 2'b00,
    LPMR_CMD_MRW = 2'b01,
    LPMR_CMD_MRR = 2'b10
  } lpmr_cmd_t;
endpackage : lpmr_pkg

// *** hdl/lpmr_if.sv ***
// Command bus between controller and mode register bank
`timescale 1ns/1ps
interface lpmr_if;
  logic cke;
  lpmr_pkg::lpmr_cmd_t cmd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rdata_oe;
  logic strobe_toggle;
  logic rvalid;
  modport ctrl (output cke, output cmd, output addr, output wdata, input rdata, input rdata_oe,
    input strobe_toggle, input rvalid);
  modport dev (input cke, input cmd, input addr, input wdata, output rdata, output rdata_oe,
    output strobe_toggle, output rvalid);
endinterface : lpmr_if

// *** hdl/lpmr_device.sv ***
// Mode register bank of the memory device
`timescale 1ns/1ps
// Contract
// - Controller holds CKE low 100 ns first
// - Controller clocks five periods before CKE high
// - Controller idles 200 us before reset write; a reinit_req during that wait sends the reset write at once
// - Controller idles 1 us after reset write
// - Device finishes auto init within 10 us
// - Controller waits 1 us after calibration
// - Boot reads need 18 to 100 ns clock
// - Later reset restarts from reset step
// - Controller holds CKE low at power removal
// - Outputs high impedance while CKE low; rdata_oe is also low whenever no read answer is due
// - Read and write commands use 8-bit address
// - Calibration patterns readable at 20H and 28H
// - Controller avoids maker and do-not-use addresses
// - Controller writes reserved bits as zero
// - Device reads reserved bits as zero
// - Reserved or write-only reads give undefined, strobe toggles
// - Controller never writes fully reserved registers
// - Writes to read-only registers change nothing
// - Status bit set during init, cleared after
// - During init only reads and power-down allowed
module lpmr_device #(
  parameter int unsigned AUTO_INIT_CYC = lpmr_pkg::AUTO_INIT_MAX_TIME_CYC,
  parameter logic [7:0] MAKER_ID = 8'h5A,
  parameter logic [7:0] REV_FIRST = 8'h01,
  parameter logic [7:0] REV_SECOND = 8'h00,
  parameter logic [7:0] WIDTH_DENSITY = 8'h14,
  parameter logic [7:0] PATTERN_A = 8'h55,
  parameter logic [7:0] PATTERN_B = 8'h33
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Command bus
  lpmr_if.dev bus,
  // User side
  output logic init_done,
  output logic [7:0] feature_one,
  output logic [7:0] feature_two,
  output logic [7:0] io_config,
  output logic [7:0] bank_mask,
  output logic [7:0] cal_code
);
  // Maker and revision values above are arbitrary
  typedef enum logic [1:0] {
    LPMR_DEV_IDLE = 2'b00,
    LPMR_DEV_INIT = 2'b01,
    LPMR_DEV_READY = 2'b10
  } lpmr_dev_state_t;

  function automatic logic [7:0] lpmr_read_map(input logic [7:0] a, input logic [7:0] info);
    case (a)
      lpmr_pkg::ADDR_DEVICE_INFORMATION: lpmr_read_map = info & lpmr_pkg::DEVICE_INFO_USED_MASK;
      lpmr_pkg::ADDR_REFRESH_RATE_STATUS: lpmr_read_map = lpmr_pkg::REFRESH_RATE_RESET & lpmr_pkg::REFRESH_RATE_USED_MASK;
      lpmr_pkg::ADDR_MAKER_IDENTIFICATION: lpmr_read_map = MAKER_ID;
      lpmr_pkg::ADDR_REVISION_FIRST: lpmr_read_map = REV_FIRST;
      lpmr_pkg::ADDR_REVISION_SECOND: lpmr_read_map = REV_SECOND;
      lpmr_pkg::ADDR_WIDTH_DENSITY_TYPE: lpmr_read_map = WIDTH_DENSITY;
      lpmr_pkg::ADDR_CALIBRATION_PATTERN_A: lpmr_read_map = PATTERN_A;
      lpmr_pkg::ADDR_CALIBRATION_PATTERN_B: lpmr_read_map = PATTERN_B;
      default: lpmr_read_map = lpmr_pkg::UNDEFINED_READ_DATA;
    endcase
  endfunction : lpmr_read_map

  lpmr_dev_state_t state_reg, state_next;
  logic [23:0] init_cnt_reg;
  logic [7:0] info_reg;
  logic [7:0] f1_reg, f2_reg, io_reg, mask_reg, cal_reg;
  logic [lpmr_pkg::READ_LATENCY-1:0] rd_pipe_reg;
  logic [7:0] rd_data_reg;
  logic rd_oe_reg, strobe_reg, rvalid_reg;
  logic init_done_reg;

  wire is_mrw = (bus.cmd == lpmr_pkg::LPMR_CMD_MRW) && bus.cke;
  wire is_mrr = (bus.cmd == lpmr_pkg::LPMR_CMD_MRR) && bus.cke;
  wire is_reset = is_mrw && (bus.addr == lpmr_pkg::ADDR_SOFTWARE_RESET);
  wire wr_ok = is_mrw && (state_reg == LPMR_DEV_READY);
  wire init_end = (state_reg == LPMR_DEV_INIT) && (init_cnt_reg == 24'(AUTO_INIT_CYC - 1));
  wire [7:0] rd_value = lpmr_read_map(bus.addr, info_reg);
  wire rd_issue = rd_pipe_reg[lpmr_pkg::READ_LATENCY-1];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      LPMR_DEV_IDLE: if (is_reset) state_next = LPMR_DEV_INIT;
      LPMR_DEV_INIT: if (init_end) state_next = LPMR_DEV_READY;
      LPMR_DEV_READY: if (is_reset) state_next = LPMR_DEV_INIT;
      default: state_next = LPMR_DEV_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= LPMR_DEV_IDLE;
      init_cnt_reg <= 24'h000000;
      info_reg <= 8'h01;
      init_done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      init_done_reg <= state_next == LPMR_DEV_READY;
      init_cnt_reg <= (state_reg == LPMR_DEV_INIT && !is_reset) ? init_cnt_reg + 24'h000001 : 24'h000000;
      if (is_reset) info_reg <= 8'h01;
      else if (init_end) info_reg <= 8'h00;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      f1_reg <= lpmr_pkg::FEATURE_ONE_RESET;
      f2_reg <= 8'h00;
      io_reg <= 8'h00;
      mask_reg <= 8'h00;
      cal_reg <= 8'h00;
    end else if (wr_ok) begin
      case (bus.addr)
        lpmr_pkg::ADDR_DEVICE_FEATURE_ONE: f1_reg <= bus.wdata;
        lpmr_pkg::ADDR_DEVICE_FEATURE_TWO: f2_reg <= bus.wdata;
        lpmr_pkg::ADDR_IO_CONFIGURATION: io_reg <= bus.wdata;
        lpmr_pkg::ADDR_PARTIAL_REFRESH_BANK_MASK: mask_reg <= bus.wdata;
        lpmr_pkg::ADDR_IO_CALIBRATION_COMMAND: cal_reg <= bus.wdata;
        default: cal_reg <= cal_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_pipe_reg <= '0;
      rd_data_reg <= 8'h00;
      rd_oe_reg <= 1'b0;
      strobe_reg <= 1'b0;
      rvalid_reg <= 1'b0;
    end else begin
      rd_pipe_reg <= {rd_pipe_reg[lpmr_pkg::READ_LATENCY-2:0], is_mrr};
      if (is_mrr) rd_data_reg <= rd_value;
      rd_oe_reg <= rd_issue && bus.cke;
      strobe_reg <= rd_issue && bus.cke;
      rvalid_reg <= rd_issue;
    end
  end

  assign bus.rdata = rd_data_reg;
  assign bus.rdata_oe = rd_oe_reg;
  assign bus.strobe_toggle = strobe_reg;
  assign bus.rvalid = rvalid_reg;
  assign init_done = init_done_reg;
  assign feature_one = f1_reg;
  assign feature_two = f2_reg;
  assign io_config = io_reg;
  assign bank_mask = mask_reg;
  assign cal_code = cal_reg;
endmodule : lpmr_device

// *** hdl/lpmr_ctrl.sv ***
// Controller init sequencer and mode register access
`timescale 1ns/1ps
module lpmr_ctrl #(
  parameter int unsigned CKE_LOW_CYC = lpmr_pkg::CKE_LOW_WAIT_CYC,
  parameter int unsigned POST_CKE_CYC = lpmr_pkg::POST_CKE_IDLE_WAIT_CYC,
  parameter int unsigned POST_RESET_CYC = lpmr_pkg::POST_RESET_IDLE_WAIT_CYC,
  parameter int unsigned AUTO_INIT_CYC = lpmr_pkg::AUTO_INIT_MAX_TIME_CYC,
  parameter int unsigned ZQ_CYC = lpmr_pkg::ZQ_INIT_WAIT_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Command bus
  lpmr_if.ctrl bus,
  // User side
  input wire logic reinit_req,
  input wire logic power_off_req,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  output logic ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data
);
  typedef enum logic [2:0] {
    LPMR_C_CKE_LOW = 3'b000,
    LPMR_C_POST_CKE = 3'b001,
    LPMR_C_POST_RST = 3'b010,
    LPMR_C_AUTO = 3'b011,
    LPMR_C_ZQ = 3'b100,
    LPMR_C_RUN = 3'b101,
    LPMR_C_OFF = 3'b110
  } lpmr_ctrl_state_t;

  function automatic logic lpmr_addr_bad(input logic [7:0] a);
    lpmr_addr_bad = a[7] || a == 8'h7F;
  endfunction : lpmr_addr_bad

  lpmr_ctrl_state_t st_reg;
  logic [23:0] cnt_reg;
  logic cke_reg;
  lpmr_pkg::lpmr_cmd_t cmd_reg;
  logic [7:0] addr_reg, wdata_reg, rsp_reg;
  logic rsp_v_reg, ready_reg;
  localparam int unsigned LOW_CYC = (CKE_LOW_CYC > lpmr_pkg::CLOCK_STABLE_WAIT_CYC) ?
    CKE_LOW_CYC : lpmr_pkg::CLOCK_STABLE_WAIT_CYC;

  wire cnt_done = cnt_reg == 24'h000000;
  wire run = st_reg == LPMR_C_RUN;
  wire rsvd_wr = (req_addr >= 8'h0B && req_addr <= 8'h0F) || req_addr == lpmr_pkg::ADDR_RESERVED_WRITABLE ||
    (req_addr >= 8'h12 && req_addr <= 8'h3E && req_addr != lpmr_pkg::ADDR_CALIBRATION_PATTERN_A &&
    req_addr != lpmr_pkg::ADDR_CALIBRATION_PATTERN_B) || (req_addr >= 8'h40);
  wire take = run && req_valid && !lpmr_addr_bad(req_addr) && !(req_write && rsvd_wr);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= LPMR_C_CKE_LOW;
      cnt_reg <= 24'(LOW_CYC);
      cke_reg <= 1'b0;
      cmd_reg <= lpmr_pkg::LPMR_CMD_NOP;
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      ready_reg <= 1'b0;
    end else begin
      cmd_reg <= lpmr_pkg::LPMR_CMD_NOP;
      cnt_reg <= cnt_done ? cnt_reg : cnt_reg - 24'h000001;
      if (power_off_req) begin
        st_reg <= LPMR_C_OFF;
        cke_reg <= 1'b0;
        ready_reg <= 1'b0;
      end else if (reinit_req && st_reg != LPMR_C_CKE_LOW && st_reg != LPMR_C_OFF) begin
        st_reg <= LPMR_C_POST_RST;
        cmd_reg <= lpmr_pkg::LPMR_CMD_MRW;
        addr_reg <= lpmr_pkg::ADDR_SOFTWARE_RESET;
        wdata_reg <= 8'h00;
        cnt_reg <= 24'(POST_RESET_CYC);
        ready_reg <= 1'b0;
      end else begin
        case (st_reg)
          LPMR_C_CKE_LOW: if (cnt_done) begin
            cke_reg <= 1'b1;
            st_reg <= LPMR_C_POST_CKE;
            cnt_reg <= 24'(POST_CKE_CYC);
          end
          LPMR_C_POST_CKE: if (cnt_done) begin
            cmd_reg <= lpmr_pkg::LPMR_CMD_MRW;
            addr_reg <= lpmr_pkg::ADDR_SOFTWARE_RESET;
            wdata_reg <= 8'h00;
            st_reg <= LPMR_C_POST_RST;
            cnt_reg <= 24'(POST_RESET_CYC);
          end
          LPMR_C_POST_RST: if (cnt_done) begin
            st_reg <= LPMR_C_AUTO;
            cnt_reg <= 24'(AUTO_INIT_CYC);
          end
          LPMR_C_AUTO: if (cnt_done) begin
            cmd_reg <= lpmr_pkg::LPMR_CMD_MRW;
            addr_reg <= lpmr_pkg::ADDR_IO_CALIBRATION_COMMAND;
            wdata_reg <= lpmr_pkg::ZQ_INIT_CAL_CODE;
            st_reg <= LPMR_C_ZQ;
            cnt_reg <= 24'(ZQ_CYC);
          end
          LPMR_C_ZQ: if (cnt_done) begin
            st_reg <= LPMR_C_RUN;
            ready_reg <= 1'b1;
          end
          LPMR_C_RUN: if (take) begin
            cmd_reg <= req_write ? lpmr_pkg::LPMR_CMD_MRW : lpmr_pkg::LPMR_CMD_MRR;
            addr_reg <= req_addr;
            wdata_reg <= req_wdata;
          end
          LPMR_C_OFF: cke_reg <= 1'b0;
          default: st_reg <= LPMR_C_CKE_LOW;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_reg <= 8'h00;
      rsp_v_reg <= 1'b0;
    end else begin
      rsp_v_reg <= bus.rvalid;
      if (bus.rvalid) rsp_reg <= bus.rdata;
    end
  end

  assign bus.cke = cke_reg;
  assign bus.cmd = cmd_reg;
  assign bus.addr = addr_reg;
  assign bus.wdata = wdata_reg;
  assign req_ready = ready_reg;
  assign ready = ready_reg;
  assign rsp_valid = rsp_v_reg;
  assign rsp_data = rsp_reg;
endmodule : lpmr_ctrl

// *** tb/lpmr_asserts.sv ***
// Bus checker for the mode register link
`timescale 1ns/1ps
module lpmr_asserts #(
  parameter int unsigned CKE_LOW_CYC = 20,
  parameter int unsigned POST_CKE_CYC = 10,
  parameter int unsigned AUTO_INIT_CYC = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Command bus
  input wire logic cke,
  input wire lpmr_pkg::lpmr_cmd_t cmd,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rdata_oe,
  input wire logic strobe_toggle,
  input wire logic rvalid
);
  logic [15:0] low_cnt;
  logic [15:0] hi_cnt;
  logic [15:0] rst_cnt;
  wire mrr = cke && cmd == lpmr_pkg::LPMR_CMD_MRR;
  wire mrw = cke && cmd == lpmr_pkg::LPMR_CMD_MRW;
  wire rst_cmd = mrw && addr == 8'h3F;
  wire rd_known = addr inside {8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h20, 8'h28};
  wire wr_known = rd_known || addr inside {8'h01, 8'h02, 8'h03, 8'h09, 8'h0A, 8'h10, 8'h11, 8'h3F};
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt <= 16'h0000;
      hi_cnt <= 16'h0000;
      rst_cnt <= 16'h0000;
    end else begin
      low_cnt <= cke ? 16'h0000 : (&low_cnt ? low_cnt : low_cnt + 16'h0001);
      hi_cnt <= !cke ? 16'h0000 : (&hi_cnt ? hi_cnt : hi_cnt + 16'h0001);
      rst_cnt <= rst_cmd ? 16'h0000 : (&rst_cnt ? rst_cnt : rst_cnt + 16'h0001);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Strobe, data out and valid together, four cycles after a read
  sequence s_read_answer;
    ##4 (rdata_oe && strobe_toggle && rvalid);
  endsequence
  a_read_pipe: assert property (mrr |-> s_read_answer)
    else $error("read answer timing wrong");
  a_rvalid_cause: assert property (rvalid |-> $past(mrr, 4))
    else $error("read valid without read");
  a_strobe_with_oe: assert property (strobe_toggle |-> rdata_oe && $past(mrr, 4))
    else $error("strobe without driven data");
  a_rsvd_read_zero: assert property (mrr && !rd_known |-> ##4 rvalid && rdata == 8'h00)
    else $error("reserved read data wrong");
  a_info_rfu_zero: assert property (mrr && addr == 8'h00 |-> ##4 rdata[7:5] == 3'h0)
    else $error("info reserved bits set");
  a_no_vendor_addr: assert property (mrr || mrw |-> addr < 8'h80 && addr != 8'h7F)
    else $error("vendor address used");
  a_no_rsvd_write: assert property (mrw |-> wr_known)
    else $error("write to reserved address");
  a_cke_low_hold: assert property ($rose(cke) |-> low_cnt >= CKE_LOW_CYC)
    else $error("clock enable low too short");
  a_post_cke_idle: assert property (rst_cmd |-> hi_cnt >= POST_CKE_CYC)
    else $error("reset command too early");
  a_post_reset_idle: assert property (rst_cmd |=> (cmd == lpmr_pkg::LPMR_CMD_NOP) [*4])
    else $error("bus not idle after reset");
  a_init_only_reads: assert property (mrw && !rst_cmd |-> rst_cnt >= AUTO_INIT_CYC)
    else $error("write during auto init");
  a_cke_low_quiet: assert property (!cke |-> !rdata_oe && !strobe_toggle)
    else $error("data driven with clock enable low");
endmodule : lpmr_asserts

// *** tb/testbench.sv ***
// Self-checking bench for both ends of the mode register link
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] RD_A [6] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h20, 8'h28};
  // Arbitrary identity and pattern values
  localparam logic [7:0] RD_E [6] = '{8'hA6, 8'h02, 8'h01, 8'h18, 8'h5C, 8'hC3};
  localparam logic [7:0] Z_A [9] = '{8'h01, 8'h02, 8'h03, 8'h09, 8'h0A, 8'h10, 8'h0B, 8'h21, 8'h3E};
  // Wait counts for simulation, all shortened except T_LOW
  localparam int unsigned T_LOW = 20;
  localparam int unsigned T_POST_CKE = 10;
  localparam int unsigned T_POST_RST = 4;
  localparam int unsigned T_AUTO = 20;
  localparam int unsigned T_ZQ = 4;
  localparam int unsigned T_DEV_AUTO = 16;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic reinit_req = 1'b0;
  logic power_off_req = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_wdata = 8'h00;
  logic req_ready, ready, rsp_valid, init_done;
  logic [7:0] rsp_data, feature_one, feature_two, io_config, bank_mask, cal_code;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  lpmr_if bus_if();
  always #2.5 core_clk = ~core_clk;
  lpmr_device #(.AUTO_INIT_CYC(T_DEV_AUTO), .MAKER_ID(RD_E[0]), .REV_FIRST(RD_E[1]), .REV_SECOND(RD_E[2]),
    .WIDTH_DENSITY(RD_E[3]), .PATTERN_A(RD_E[4]), .PATTERN_B(RD_E[5])) lpmr_device_i (
    .core_clk(core_clk), .rst_b(rst_b), .bus(bus_if), .init_done(init_done), .feature_one(feature_one),
    .feature_two(feature_two), .io_config(io_config), .bank_mask(bank_mask), .cal_code(cal_code));
  lpmr_ctrl #(.CKE_LOW_CYC(T_LOW), .POST_CKE_CYC(T_POST_CKE), .POST_RESET_CYC(T_POST_RST), .AUTO_INIT_CYC(T_AUTO),
    .ZQ_CYC(T_ZQ)) lpmr_ctrl_i (
    .core_clk(core_clk), .rst_b(rst_b), .bus(bus_if), .reinit_req(reinit_req), .power_off_req(power_off_req),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .ready(ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  lpmr_asserts #(.CKE_LOW_CYC(T_LOW), .POST_CKE_CYC(T_POST_CKE), .AUTO_INIT_CYC(T_AUTO)) lpmr_asserts_i (
    .core_clk(core_clk), .rst_b(rst_b), .cke(bus_if.cke), .cmd(bus_if.cmd), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .rdata(bus_if.rdata), .rdata_oe(bus_if.rdata_oe),
    .strobe_toggle(bus_if.strobe_toggle), .rvalid(bus_if.rvalid));
  task automatic end_sim;
    $display("Counts: errors=%0d checks=%0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Wait for ready (sel 0) or init done (sel 1)
  task automatic wait_lvl(input logic sel, input logic lvl);
    int n;
    n = 0;
    while ((sel ? init_done : ready) !== lvl && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    chk({7'h00, sel ? init_done : ready}, {7'h00, lvl});
  endtask : wait_lvl
  task automatic req(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge core_clk);
    req_valid = 1'b0;
  endtask : req
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    int n;
    n = 0;
    req(1'b0, a, 8'h00);
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    chk({7'h00, rsp_valid}, 8'h01);
    chk(rsp_data & m, exp);
  endtask : rd
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_sim;
    end
  end
  initial begin
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    chk({7'h00, bus_if.cke}, 8'h00);
    wait_lvl(1'b0, 1'b1);
    chk({7'h00, init_done}, 8'h01);
    chk(cal_code, 8'hFF);
    rd(8'h00, 8'h01, 8'h00);
    rd(8'h00, 8'hE0, 8'h00);
    rd(8'h04, 8'hFF, 8'h03);
    for (int i = 0; i < 6; i++) rd(RD_A[i], 8'hFF, RD_E[i]);
    for (int i = 0; i < 9; i++) rd(Z_A[i], 8'hFF, 8'h00);
    req(1'b1, 8'h01, 8'h43);
    req(1'b1, 8'h02, 8'h04);
    req(1'b1, 8'h03, 8'h02);
    req(1'b1, 8'h10, 8'hF0);
    req(1'b1, 8'h05, 8'hAA);
    req(1'b1, 8'h20, 8'hAA);
    req(1'b1, 8'h85, 8'h11);
    req(1'b1, 8'h0B, 8'h11);
    req(1'b1, 8'hFF, 8'h11);
    repeat (2) @(negedge core_clk);
    chk(feature_one, 8'h43);
    chk(feature_two, 8'h04);
    chk(io_config, 8'h02);
    chk(bank_mask, 8'hF0);
    rd(8'h05, 8'hFF, RD_E[0]);
    rd(8'h20, 8'hFF, RD_E[4]);
    rd(8'h01, 8'hFF, 8'h00);
    reinit_req = 1'b1;
    @(negedge core_clk);
    reinit_req = 1'b0;
    wait_lvl(1'b0, 1'b0);
    wait_lvl(1'b1, 1'b0);
    chk({7'h00, bus_if.cke}, 8'h01);
    wait_lvl(1'b0, 1'b1);
    rd(8'h00, 8'h01, 8'h00);
    power_off_req = 1'b1;
    repeat (3) @(negedge core_clk);
    chk({7'h00, bus_if.cke}, 8'h00);
    chk({7'h00, bus_if.rdata_oe}, 8'h00);
    rst_b = 1'b0;
    power_off_req = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    wait_lvl(1'b0, 1'b1);
    rd(8'h28, 8'hFF, RD_E[5]);
    end_sim;
  end
endmodule : testbench
